// ---- hw/hub_seq_consts.svh ----
// Timing, strap and reset constants for the hub reset/config sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef HUB_SEQ_CONSTS_SVH
`define HUB_SEQ_CONSTS_SVH

`define CLK_MHZ             100
`define RST_MIN_NS          1000
`define OUT_INACT_MAX_NS    2000
`define RECOVER_MAX_US      500
`define EE_CFG_MAX_US       99500
`define ATTACH_MAX_US       100000
`define REQ_MAX_US          5000
`define OUT_INACT_CYC       ((`OUT_INACT_MAX_NS * `CLK_MHZ) / 1000)
`define RECOVER_CYC        (`RECOVER_MAX_US * `CLK_MHZ)
`define EE_CFG_CYC         (`EE_CFG_MAX_US * `CLK_MHZ)
`define ATTACH_CYC         (`ATTACH_MAX_US * `CLK_MHZ)
`define REQ_CYC            (`REQ_MAX_US * `CLK_MHZ)
`define CNT_W               24
`define LED_W               3
`define PORT_W              8
`define ADDR_W              7
`define ADDR_RST            7'h00
`define PWR_RST             8'h00
`define REG_DEFAULT         32'h00000000
`define SEL_DEFAULT         2'h0
`define SEL_EEPROM          2'h1
`define SEL_SMBUS           2'h2
`define SEL_SMBUS_B         2'h3
`define ID_CODE             32'h00C0FFEE
`define REG_CTRL            4'h0
`define REG_STAT            4'h4
`define REG_ID              4'h8

`endif

// ---- hw/hub_seq_pkg.sv ----
// Types used by the sequencer; its bus slave does not use them.
// Assumes the constants header is compiled alongside.
package hub_seq_pkg;
   typedef enum logic [1:0] {
      CFG_STRAP,
      CFG_EEPROM,
      CFG_SMBUS
   } cfg_mode_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_RECOVER,
      ST_LOAD,
      ST_APPLY,
      ST_ATTACHED,
      ST_ERROR
   } seq_state_t;
endpackage

// ---- hw/hub_seq_regs.sv ----
// Avalon-MM slave holding the control, status and id words.
// Assumes a synchronous master on clk_i; one wait cycle per access.
`timescale 1ns/1ps
`include "hub_seq_consts.svh"

module hub_seq_regs (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Avalon-MM slave
   input  wire logic [3:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // Block side
   input  wire logic [31:0] status_i,
   output logic      [31:0] ctrl_o
);
   logic        ack_r;
   logic [31:0] ctrl_r;
   logic [31:0] rd_nxt;
   wire         req = (read_i | write_i) & ~ack_r;

   assign rd_nxt = (address_i == `REG_CTRL) ? ctrl_r :
                   (address_i == `REG_STAT) ? status_i :
                   (address_i == `REG_ID)   ? `ID_CODE : `REG_DEFAULT;
   assign ctrl_o        = ctrl_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_r      <= 1'b0;
         waitrequest_o <= 1'b1;
         ctrl_r     <= `REG_DEFAULT;
         readdata_o <= `REG_DEFAULT;
      end else begin
         ack_r <= req;
         // Registered so the output comes straight from a flop
         waitrequest_o <= ~req;
         if (req & read_i) begin
            readdata_o <= rd_nxt;
         end
         // Write lands at the edge where the master sees waitrequest low
         if (write_i & ack_r & (address_i == `REG_CTRL)) begin
            ctrl_r <= writedata_i;
         end
      end
   end
endmodule

// ---- hw/hub_reset_config_sequencer.sv ----
// Reset and start-up sequencer of a USB hub core.
// Assumes the hub clock also runs during hardware reset; pins async.
// What this block does
// - In strap mode, sample LED straps after reset release; rest defaults.
// - Strap high makes LED active low; strap low makes it active high.
// - During reset, downstream ports disabled and power enables off.
// - During reset, transceivers off and pairs high impedance.
// - Reset ends every transaction at once, keeping no state.
// - Reset returns all registers to defaults, mostly zero.
// - During reset, oscillator and PLL stop; LEDs off.
// - Operational at most 500 us after reset release.
// - In EEPROM mode, start reading EEPROM once operational.
// - Strap mode drives outputs inactive within 2 us of release.
// - Strap mode attaches upstream within 100 ms.
// - EEPROM read and config done within 99.5 ms after recovery.
// - SMBus mode attaches within 100 ms after load completes.
// - Each host request completes within 5 ms.
// - USB bus reset clears address to 0 and unconfigures.
// - USB bus reset drops power enables of ports 7 to 1.
// - USB bus reset clears TT buffers and leaves suspend.
// - USB bus reset is never forwarded downstream.
// - SMBus mode never uses the EEPROM.
// - SMBus mode waits unbounded for load, attaches only after.
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "hub_seq_consts.svh"

module hub_reset_config_sequencer (
   // Clock and synchronous reset
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   // External hardware reset pin, active low, asynchronous
   input  wire logic               hw_reset_n_i,
   // Straps and configuration source select pins
   input  wire logic [`LED_W-1:0]  led_strap_i,
   input  wire logic               config_source_select_hi_i,
   input  wire logic               config_source_select_lo_i,
   // Configuration loaders
   input  wire logic               ee_done_i,
   input  wire logic               smbus_load_done_i,
   input  wire logic               bus_powered_i,
   // Upstream USB events from the hub core
   input  wire logic               usb_bus_reset_i,
   input  wire logic               req_start_i,
   input  wire logic               req_done_i,
   input  wire logic               set_config_i,
   input  wire logic [`ADDR_W-1:0] set_addr_i,
   input  wire logic               set_addr_valid_i,
   input  wire logic               suspend_i,
   input  wire logic [`PORT_W-1:0] port_power_req_i,
   // Avalon-MM slave
   input  wire logic [3:0]         address_i,
   input  wire logic               read_i,
   input  wire logic               write_i,
   input  wire logic [31:0]        writedata_i,
   output logic      [31:0]        readdata_o,
   output logic                    waitrequest_o,
   // Outputs toward the hub
   output logic                    osc_enable_o,
   output logic                    pll_enable_o,
   output logic                    phy_enable_o,
   output logic                    dp_oe_o,
   output logic [`PORT_W-1:0]      port_enable_o,
   output logic [`PORT_W-1:0]      port_power_enable_o,
   output logic [`LED_W-1:0]       led_o,
   output logic [`LED_W-1:0]       led_oe_o,
   output logic                    abort_all_o,
   output logic                    ee_read_start_o,
   output logic                    smbus_enable_o,
   output logic                    usb_attach_o,
   output logic [`ADDR_W-1:0]      usb_addr_o,
   output logic                    configured_o,
   output logic                    tt_clear_o,
   output logic                    suspended_o,
   output logic                    downstream_reset_o,
   output logic                    timeout_o
);
   ////////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic               rst_n_m_r;
   logic               rst_n_s_r;
   logic               busrst_m_r;
   logic               busrst_s_r;
   logic               busrst_d_r;
   logic [1:0]         sel_m_r;
   logic [1:0]         sel_s_r;
   logic [`LED_W-1:0]  strap_m_r;
   logic [`LED_W-1:0]  strap_s_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rst_n_m_r  <= 1'b0;
         rst_n_s_r  <= 1'b0;
         busrst_m_r <= 1'b0;
         busrst_s_r <= 1'b0;
         busrst_d_r <= 1'b0;
         sel_m_r    <= `SEL_DEFAULT;
         sel_s_r    <= `SEL_DEFAULT;
         strap_m_r  <= '0;
         strap_s_r  <= '0;
      end else begin
         rst_n_m_r  <= hw_reset_n_i;
         rst_n_s_r  <= rst_n_m_r;
         busrst_m_r <= usb_bus_reset_i;
         busrst_s_r <= busrst_m_r;
         busrst_d_r <= busrst_s_r;
         sel_m_r    <= {config_source_select_hi_i,
                        config_source_select_lo_i};
         sel_s_r    <= sel_m_r;
         strap_m_r  <= led_strap_i;
         strap_s_r  <= strap_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode
   function automatic hub_seq_pkg::cfg_mode_t mode_of(input logic [1:0] s);
      if (s == `SEL_EEPROM) begin
         return hub_seq_pkg::CFG_EEPROM;
      end else if (s[1]) begin
         return hub_seq_pkg::CFG_SMBUS;
      end
      return hub_seq_pkg::CFG_STRAP;
   endfunction

   function automatic logic hit(input logic [`CNT_W-1:0] c,
                                input logic [`CNT_W-1:0] lim);
      return c >= lim;
   endfunction

   localparam logic [`CNT_W-1:0] INACT_LIM = `CNT_W'(`OUT_INACT_CYC - 2);
   localparam logic [`CNT_W-1:0] RECOV_LIM = `CNT_W'(`RECOVER_CYC - 2);
   localparam logic [`CNT_W-1:0] EE_LIM    = `CNT_W'(`EE_CFG_CYC - 2);
   localparam logic [`CNT_W-1:0] ATT_LIM   = `CNT_W'(`ATTACH_CYC - 4);
   localparam logic [`CNT_W-1:0] REQ_LIM   = `CNT_W'(`REQ_CYC - 2);

   wire in_reset   = ~rst_n_s_r;
   wire bus_rst_ev = busrst_s_r & ~busrst_d_r;

   hub_seq_pkg::seq_state_t st_r;
   hub_seq_pkg::seq_state_t st_nxt;
   hub_seq_pkg::cfg_mode_t  mode_r;
   logic [`CNT_W-1:0]  cnt_r;
   logic [`CNT_W-1:0]  att_cnt_r;
   logic [`CNT_W-1:0]  req_cnt_r;
   logic               req_busy_r;
   logic [`LED_W-1:0]  pol_r;
   logic               strap_taken_r;
   logic               first_r;
   logic [31:0]        ctrl_w;
   logic [31:0]        status_w;

   // Software may force the self-powered unbounded SMBus wait off
   wire sw_bus_pwr = ctrl_w[0];
   wire limit_load = bus_powered_i | sw_bus_pwr;

   ////////////////////////////////////////////////////////////////////////
   // Sequence state machine
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         hub_seq_pkg::ST_RESET: begin
            st_nxt = hub_seq_pkg::ST_RECOVER;
         end
         hub_seq_pkg::ST_RECOVER: begin
            if (hit(cnt_r, RECOV_LIM)) begin
               st_nxt = (mode_r == hub_seq_pkg::CFG_STRAP) ?
                        hub_seq_pkg::ST_APPLY : hub_seq_pkg::ST_LOAD;
            end
         end
         hub_seq_pkg::ST_LOAD: begin
            if (mode_r == hub_seq_pkg::CFG_EEPROM) begin
               if (ee_done_i) begin
                  st_nxt = hub_seq_pkg::ST_APPLY;
               end else if (hit(cnt_r, EE_LIM)) begin
                  st_nxt = hub_seq_pkg::ST_ERROR;
               end
            end else if (smbus_load_done_i) begin
               st_nxt = hub_seq_pkg::ST_APPLY;
            end
         end
         hub_seq_pkg::ST_APPLY: begin
            st_nxt = hub_seq_pkg::ST_ATTACHED;
         end
         hub_seq_pkg::ST_ATTACHED: begin
            st_nxt = st_r;
         end
         hub_seq_pkg::ST_ERROR: begin
            st_nxt = st_r;
         end
         default: begin
            st_nxt = hub_seq_pkg::ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i | in_reset) begin
         st_r  <= hub_seq_pkg::ST_RESET;
         cnt_r <= '0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= (st_nxt != st_r) ? '0 : cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i | in_reset) begin
         strap_taken_r <= 1'b0;
         pol_r         <= '0;
         mode_r        <= hub_seq_pkg::CFG_STRAP;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         mode_r        <= mode_of(sel_s_r);
         // Straps apply only in default mode; others keep defaults
         pol_r <= (mode_of(sel_s_r) == hub_seq_pkg::CFG_STRAP) ?
                  strap_s_r : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   wire live   = ~in_reset & ~reset_i;
   wire up     = live & (st_r == hub_seq_pkg::ST_ATTACHED);
   wire loadng = live & (st_r == hub_seq_pkg::ST_LOAD);

   always_ff @(posedge clk_i) begin
      if (reset_i | in_reset) begin
         port_enable_o       <= `PWR_RST;
         port_power_enable_o <= `PWR_RST;
         phy_enable_o        <= 1'b0;
         dp_oe_o             <= 1'b0;
         osc_enable_o        <= 1'b0;
         pll_enable_o        <= 1'b0;
         led_o               <= '0;
         led_oe_o            <= '0;
         abort_all_o         <= 1'b1;
         ee_read_start_o     <= 1'b0;
         smbus_enable_o      <= 1'b0;
         usb_attach_o        <= 1'b0;
         usb_addr_o          <= `ADDR_RST;
         configured_o        <= 1'b0;
         tt_clear_o          <= 1'b1;
         suspended_o         <= 1'b0;
         first_r             <= 1'b1;
      end else begin
         first_r         <= 1'b0;
         abort_all_o     <= 1'b0;
         osc_enable_o    <= 1'b1;
         pll_enable_o    <= 1'b1;
         led_oe_o        <= strap_taken_r ? '1 : '0;
         led_o           <= pol_r;
         ee_read_start_o <= (st_nxt == hub_seq_pkg::ST_LOAD) &
                            (st_r == hub_seq_pkg::ST_RECOVER) &
                            (mode_r == hub_seq_pkg::CFG_EEPROM);
         smbus_enable_o  <= loadng & (mode_r == hub_seq_pkg::CFG_SMBUS);
         usb_attach_o    <= up;
         phy_enable_o    <= up;
         dp_oe_o         <= up;
         port_enable_o   <= up ? '1 : '0;
         if (bus_rst_ev) begin
            usb_addr_o          <= `ADDR_RST;
            configured_o        <= 1'b0;
            port_power_enable_o <= port_power_enable_o & `PORT_W'(8'h01);
            tt_clear_o          <= 1'b1;
            suspended_o         <= 1'b0;
         end else begin
            tt_clear_o <= 1'b0;
            if (set_addr_valid_i & up) begin
               usb_addr_o <= set_addr_i;
            end
            if (set_config_i & up) begin
               configured_o <= 1'b1;
            end
            port_power_enable_o <= up ? port_power_req_i : '0;
            suspended_o         <= up & suspend_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      downstream_reset_o <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdogs on attach and host request bounds
   // Request and attach bounds
   always_ff @(posedge clk_i) begin
      if (reset_i | in_reset) begin
         att_cnt_r  <= '0;
         req_cnt_r  <= '0;
         req_busy_r <= 1'b0;
         timeout_o  <= 1'b0;
      end else begin
         if (req_start_i) begin
            req_busy_r <= 1'b1;
            req_cnt_r  <= '0;
         end else if (req_done_i) begin
            req_busy_r <= 1'b0;
         end else if (req_busy_r) begin
            req_cnt_r <= req_cnt_r + 1'b1;
         end
         if ((st_r == hub_seq_pkg::ST_LOAD) &
             (mode_r == hub_seq_pkg::CFG_SMBUS) & limit_load) begin
            att_cnt_r <= att_cnt_r + 1'b1;
         end
         if ((req_busy_r & hit(req_cnt_r, REQ_LIM)) |
             hit(att_cnt_r, EE_LIM) |
             (st_r == hub_seq_pkg::ST_ERROR)) begin
            timeout_o <= 1'b1;
         end
      end
   end

   assign status_w = {24'h0, 1'b0, st_r, 2'(mode_r), usb_attach_o,
                      timeout_o};

   hub_seq_regs u_regs (
      .clk_i         (clk_i),
      .reset_i       (reset_i | in_reset),
      .address_i     (address_i),
      .read_i        (read_i),
      .write_i       (write_i),
      .writedata_i   (writedata_i),
      .readdata_o    (readdata_o),
      .waitrequest_o (waitrequest_o),
      .status_i      (status_w),
      .ctrl_o        (ctrl_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Power off in reset
   property p_pwr_reset;
      @(posedge clk_i) disable iff (reset_i)
      $past(in_reset) |-> port_power_enable_o == '0;
   endproperty
   a_pwr_reset: assert property (p_pwr_reset)
      else $error("port power on during reset");

   property p_phy_reset;
      @(posedge clk_i) disable iff (reset_i)
      $past(in_reset) |-> !phy_enable_o && !dp_oe_o;
   endproperty
   a_phy_reset: assert property (p_phy_reset)
      else $error("phy active during reset");

   property p_osc_reset;
      @(posedge clk_i) disable iff (reset_i)
      $past(in_reset) |-> !osc_enable_o && !pll_enable_o && led_oe_o == '0;
   endproperty
   a_osc_reset: assert property (p_osc_reset)
      else $error("clocks or leds on during reset");

   // Own count of recovery cycles, too long for a delay range
   logic [`CNT_W-1:0]  rec_cnt_r;
   always_ff @(posedge clk_i) begin
      if (reset_i | in_reset) begin
         rec_cnt_r <= '0;
      end else if (st_r == hub_seq_pkg::ST_RECOVER) begin
         rec_cnt_r <= rec_cnt_r + 1'b1;
      end
   end
   property p_recover;
      @(posedge clk_i) disable iff (reset_i | in_reset)
      st_r == hub_seq_pkg::ST_RECOVER |->
         rec_cnt_r < `CNT_W'(`RECOVER_CYC);
   endproperty
   a_recover: assert property (p_recover)
      else $error("recovery too long");

   property p_inact;
      @(posedge clk_i) disable iff (reset_i | in_reset)
      $rose(strap_taken_r) |-> ##1 led_oe_o == '1 ##1 led_o == pol_r;
   endproperty
   a_inact: assert property (p_inact)
      else $error("leds not driven after straps");

   sequence s_busrst;
      $rose(busrst_s_r) && !in_reset;
   endsequence
   property p_busrst;
      @(posedge clk_i) disable iff (reset_i)
      s_busrst ##1 !in_reset |-> usb_addr_o == '0 && !configured_o
         && port_power_enable_o[7:1] == '0 && tt_clear_o && !suspended_o;
   endproperty
   a_busrst: assert property (p_busrst)
      else $error("bus reset effects missing");

   property p_noforward;
      @(posedge clk_i) disable iff (reset_i)
      s_busrst |-> ##1 !downstream_reset_o;
   endproperty
   a_noforward: assert property (p_noforward)
      else $error("bus reset forwarded");

   property p_smb_ee;
      @(posedge clk_i) disable iff (reset_i | in_reset)
      mode_r == hub_seq_pkg::CFG_SMBUS |-> ##1 !ee_read_start_o;
   endproperty
   a_smb_ee: assert property (p_smb_ee)
      else $error("eeprom used in smbus mode");

   property p_smb_wait;
      @(posedge clk_i) disable iff (reset_i | in_reset)
      st_r == hub_seq_pkg::ST_LOAD && !smbus_load_done_i &&
      mode_r == hub_seq_pkg::CFG_SMBUS |-> ##1 !usb_attach_o;
   endproperty
   a_smb_wait: assert property (p_smb_wait)
      else $error("attached before load");
endmodule

// ---- verif/hub_host_model.sv ----
// Board reset source and upstream host seen from the sequencer's pins.
// Assumes the bench pulses start_reset_i for one clk_i cycle.
`timescale 1ns/1ps

module hub_host_model #(
   parameter int RST_CYC  = 120,
   parameter int WAIT_CYC = 200
) (
   // Clock
   input  wire logic clk_i,
   // Bench control
   input  wire logic start_reset_i,
   input  wire logic bus_reset_en_i,
   // Device side
   input  wire logic usb_attach_i,
   output logic      hw_reset_n_o,
   output logic      usb_bus_reset_o
);
   int rst_cnt_r;
   int ack_cnt_r;

   initial begin
      hw_reset_n_o = 1'b1;
      usb_bus_reset_o = 1'b0;
      rst_cnt_r = 0;
      ack_cnt_r = 0;
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if (start_reset_i) begin
         hw_reset_n_o <= 1'b0;
         rst_cnt_r <= RST_CYC;
      end else if (rst_cnt_r > 1) begin
         rst_cnt_r <= rst_cnt_r - 1;
      end else begin
         rst_cnt_r <= 0;
         hw_reset_n_o <= 1'b1;
      end
      // wait after attach, cut short to WAIT_CYC for run length
      if (!usb_attach_i || !bus_reset_en_i) begin
         ack_cnt_r <= 0;
      end else if (ack_cnt_r < WAIT_CYC + 8) begin
         ack_cnt_r <= ack_cnt_r + 1;
      end
      usb_bus_reset_o <= (ack_cnt_r >= WAIT_CYC) && (ack_cnt_r < WAIT_CYC + 8);
   end
endmodule

// ---- verif/hub_reset_config_sequencer_tb_top.sv ----
// Self-checking bench: strap run, bus reset, then an SMBus-mode run.
// Assumes the host model drives the reset pin and the upstream bus reset.
`timescale 1ns/1ps
`include "hub_seq_consts.svh"

module hub_reset_config_sequencer_tb_top;
   logic               clk_i = 1'b0, reset_i = 1'b1, hw_reset_n_i;
   logic               start_reset = 1'b0, bus_reset_en = 1'b0;
   logic [`LED_W-1:0]  led_strap_i = '0, led_o, led_oe_o;
   logic               config_source_select_hi_i = 1'b0;
   logic               config_source_select_lo_i = 1'b0;
   logic               ee_done_i = 1'b0, smbus_load_done_i = 1'b0;
   logic               bus_powered_i = 1'b0, usb_bus_reset_i, suspend_i = 1'b0;
   logic               req_start_i = 1'b0, req_done_i = 1'b0;
   logic               set_config_i = 1'b0, set_addr_valid_i = 1'b0;
   logic [`ADDR_W-1:0] set_addr_i = '0, usb_addr_o, addr_x;
   logic [`PORT_W-1:0] port_power_req_i = '0, port_enable_o;
   logic [`PORT_W-1:0] port_power_enable_o;
   logic [3:0]         address_i = '0;
   logic               read_i = 1'b0, write_i = 1'b0, waitrequest_o;
   logic [31:0]        writedata_i = '0, readdata_o, rd;
   logic               osc_enable_o, pll_enable_o, phy_enable_o, dp_oe_o;
   logic               abort_all_o, ee_read_start_o, smbus_enable_o;
   logic               usb_attach_o, configured_o, tt_clear_o, suspended_o;
   logic               downstream_reset_o, timeout_o;
   int                 failures = 0, compares = 0, ee_starts = 0, ds_seen = 0;
   int                 n;

   hub_reset_config_sequencer hub_reset_config_sequencer_inst (.clk_i,
      .reset_i, .hw_reset_n_i, .led_strap_i, .config_source_select_hi_i,
      .config_source_select_lo_i, .ee_done_i, .smbus_load_done_i,
      .bus_powered_i, .usb_bus_reset_i, .req_start_i, .req_done_i,
      .set_config_i, .set_addr_i, .set_addr_valid_i, .suspend_i,
      .port_power_req_i, .address_i, .read_i, .write_i, .writedata_i,
      .readdata_o, .waitrequest_o, .osc_enable_o, .pll_enable_o,
      .phy_enable_o, .dp_oe_o, .port_enable_o, .port_power_enable_o, .led_o,
      .led_oe_o, .abort_all_o, .ee_read_start_o, .smbus_enable_o,
      .usb_attach_o, .usb_addr_o, .configured_o, .tt_clear_o, .suspended_o,
      .downstream_reset_o, .timeout_o);

   hub_host_model #(.RST_CYC(120), .WAIT_CYC(200)) hub_host_model_inst (
      .clk_i, .start_reset_i(start_reset), .bus_reset_en_i(bus_reset_en),
      .usb_attach_i(usb_attach_o), .hw_reset_n_o(hw_reset_n_i),
      .usb_bus_reset_o(usb_bus_reset_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (!reset_i && ee_read_start_o !== 1'b0) ee_starts++;
      if (!reset_i && downstream_reset_o !== 1'b0) ds_seen++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string nm);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, nm, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic bound(input int lim, input string nm);
      if (n >= lim) begin
         failures++;
         $display("[ERR] %0t wait for %s ran out", $time, nm);
         finish_test();
      end
   endtask

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= d;
      read_i <= !wr;
      write_i <= wr;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      bound(50, "bus answer");
      rd = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask

   task automatic hw_reset();
      @(posedge clk_i) start_reset <= 1'b1;
      @(posedge clk_i) start_reset <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(port_enable_o, 0, "ports in reset");
      check(port_power_enable_o, 0, "power in reset");
      check({phy_enable_o, dp_oe_o}, 0, "phy in reset");
      check({abort_all_o, tt_clear_o}, 2'h3, "abort in reset");
      check({osc_enable_o, pll_enable_o, led_oe_o}, 0, "clk in reset");
      for (n = 0; n < 200 && hw_reset_n_i !== 1'b1; n++) @(posedge clk_i);
      bound(200, "reset release");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      n = $urandom(99492);
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      port_power_req_i <= '1;
      led_strap_i <= $urandom;
      hw_reset();
      for (n = 0; n < `OUT_INACT_CYC && led_oe_o !== '1; n++) @(posedge clk_i);
      bound(`OUT_INACT_CYC, "led drive");
      check(led_o, led_strap_i, "led polarity");
      for (n = 0; n < `RECOVER_CYC + 100 && usb_attach_o !== 1'b1; n++)
         @(posedge clk_i);
      bound(`RECOVER_CYC + 100, "strap attach");
      check({osc_enable_o, pll_enable_o}, 2'h3, "clocks run");
      bus(0, `REG_ID, 0);
      check(rd, `ID_CODE, "id word");
      bus(1, 4'hC, $urandom);
      bus(0, 4'hC, 0);
      check(rd, 0, "unmapped read");
      bus(1, `REG_CTRL, 32'h00000001);
      addr_x = $urandom_range(127, 1);
      @(posedge clk_i) set_addr_i <= addr_x;
      set_addr_valid_i <= 1'b1;
      set_config_i <= 1'b1;
      suspend_i <= 1'b1;
      req_start_i <= 1'b1;
      @(posedge clk_i) set_addr_valid_i <= 1'b0;
      set_config_i <= 1'b0;
      req_start_i <= 1'b0;
      req_done_i <= 1'b1;
      @(posedge clk_i) req_done_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(usb_addr_o, addr_x, "address set");
      check({configured_o, suspended_o}, 2'h3, "configured");
      check(port_power_enable_o, 8'hFF, "power on");
      check(timeout_o, 0, "request done");
      $display("strap run done");
      bus_reset_en <= 1'b1;
      for (n = 0; n < 400 && tt_clear_o !== 1'b1; n++) @(posedge clk_i);
      bound(400, "tt clear");
      bus_reset_en <= 1'b0;
      check(usb_addr_o, 0, "address cleared");
      check(configured_o, 0, "unconfigured");
      check(port_power_enable_o, 8'h01, "power 7 to 1 off");
      $display("bus reset done");
      config_source_select_hi_i <= 1'b1;
      config_source_select_lo_i <= $urandom;
      ee_starts = 0;
      hw_reset();
      for (n = 0; n < `RECOVER_CYC + 100 && smbus_enable_o !== 1'b1; n++)
         @(posedge clk_i);
      bound(`RECOVER_CYC + 100, "smbus enable");
      bus(0, `REG_CTRL, 0);
      check(rd, 0, "ctrl default");
      repeat (2000) @(posedge clk_i);
      check(usb_attach_o, 0, "attach before load");
      // Load finishes well inside the host's limit
      @(posedge clk_i) smbus_load_done_i <= 1'b1;
      @(posedge clk_i) smbus_load_done_i <= 1'b0;
      for (n = 0; n < 20 && usb_attach_o !== 1'b1; n++) @(posedge clk_i);
      bound(20, "smbus attach");
      check(ee_starts, 0, "eeprom unused");
      check(ds_seen, 0, "no downstream reset");
      check(timeout_o, 0, "no watchdog");
      $display("smbus run done");
      finish_test();
   end
endmodule
